// [shared/tlpg_defines.svh]
// Overview of operation
// - cold limit code, upper nibble, read-write; 0h is -7 degC, resets to 7h.
// - hot limit code, lower nibble, read-write; 0h is 42 degC, resets to 8h.
// - raise hot interrupt when measured temperature is at or above hot limit.
// - power-good status register at 0x0F is read-only, resets to zero.
// - power-good pin released only when gate-high, source-pos, gate-low, source-neg good.
// - status bit 7 is one only while the boost converter is in regulation.
// - status bit 6 is one only while the gate-high charge pump regulates.
// - status bit 5 is one only while the inverting converter regulates.
// - status bit 4 is one only while the positive source regulator regulates.
// - status bit 3 is one only while the gate-low charge pump regulates.
// - status bit 1 is one only while the negative source regulator regulates.
// - status bits 2 and 0 always read zero.
// - revision register at 0x10 reads major, minor and version fields.
`ifndef TLPG_DEFINES_SVH
`define TLPG_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define TLPG_THR_OFS 8'h0E
`define TLPG_PGS_OFS 8'h0F
`define TLPG_REV_OFS 8'h10
`define TLPG_TSTAT_OFS 8'h20
`define TLPG_TLAST_OFS 8'h21

////////////////////////////////////////////////////////////////////////////////
// field positions
`define TLPG_COLD_MSB 7
`define TLPG_COLD_LSB 4
`define TLPG_HOT_MSB 3
`define TLPG_HOT_LSB 0
`define TLPG_PGS_BOOST_BIT 7
`define TLPG_PGS_GATEHI_BIT 6
`define TLPG_PGS_INV_BIT 5
`define TLPG_PGS_SRCPOS_BIT 4
`define TLPG_PGS_GATELO_BIT 3
`define TLPG_PGS_UNUSED2_BIT 2
`define TLPG_PGS_SRCNEG_BIT 1
`define TLPG_PGS_UNUSED0_BIT 0
`define TLPG_TSTAT_HOT_BIT 1
`define TLPG_TSTAT_COLD_BIT 0
`define TLPG_REV_MAJ_MSB 7
`define TLPG_REV_MAJ_LSB 6
`define TLPG_REV_MIN_MSB 5
`define TLPG_REV_MIN_LSB 4
`define TLPG_REV_VER_MSB 3
`define TLPG_REV_VER_LSB 0

////////////////////////////////////////////////////////////////////////////////
// reset values and temperature scale
`define TLPG_THR_RST 8'h78
`define TLPG_PGS_RST 8'h00
`define TLPG_BYTE_ZERO 8'h00
`define TLPG_HOT_BASE_DEGC 42
`define TLPG_COLD_BASE_DEGC (-7)
`define TLPG_SYNC_STAGES 2

`endif

// [shared/tlpg_pkg.sv]
package tlpg_pkg;

    // one register access per cycle; strobes never both high
    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [7:0] addr;
        logic [7:0] wrData;
    } tlpg_bus_req_t;

    // per-rail regulation flags as delivered by the analog side
    typedef struct packed {
        logic boostRailGood;
        logic gateHighRailGood;
        logic inverterRailGood;
        logic sourcePosRailGood;
        logic gateLowRailGood;
        logic sourceNegRailGood;
    } tlpg_rails_t;

    typedef enum logic [2:0] {
        TLPG_SEL_NONE,
        TLPG_SEL_THR,
        TLPG_SEL_PGS,
        TLPG_SEL_REV,
        TLPG_SEL_TSTAT,
        TLPG_SEL_TLAST
    } tlpg_sel_t;

endpackage

// [src/tlpg_sync.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tlpg_defines.svh"

module tlpg_sync #(
    parameter int WIDTH = 6
) (
    input wire logic core_clk, // core clock
    input wire logic rstn, // async reset, active low
    input wire logic [WIDTH-1:0] asyncIn, // levels from outside the domain
    output logic [WIDTH-1:0] syncOut // levels safe to use in core_clk
);

    if (WIDTH < 1) begin : g_bad_width
        $error("tlpg_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic [`TLPG_SYNC_STAGES-1:0] stage_q;
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                stage_q <= '0;
            end else begin
                stage_q <= {stage_q[0], asyncIn[i]};
            end
        end
        assign syncOut[i] = stage_q[`TLPG_SYNC_STAGES-1];
    end

endmodule
`default_nettype wire

// [src/tlpg_regs.sv]
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "tlpg_defines.svh"

module tlpg_regs #(
    parameter int TEMP_W = 8,
    parameter logic [1:0] MAJOR_REV = 2'h1, // arbitrary value
    parameter logic [1:0] MINOR_REV = 2'h2, // arbitrary value
    parameter logic [3:0] VERSION_NUM = 4'h3 // arbitrary value
) (
    input wire logic core_clk, // core clock, 100 MHz
    input wire logic rstn, // async reset, active low
    input wire tlpg_pkg::tlpg_bus_req_t busReq, // register access request
    output logic [7:0] rdData, // read data, cycle after read strobe
    input wire tlpg_pkg::tlpg_rails_t railGoodPins, // async rail good levels
    input wire logic tempValid, // new temperature sample, one cycle
    input wire logic signed [TEMP_W-1:0] tempDegC, // sample in whole degC
    output logic hotIrq, // pulse: sample at or above hot limit
    output logic coldIrq, // pulse: sample at or below cold limit
    output logic powerGoodOutputO, // power-good pin drive value
    output logic powerGoodOutputEnN // power-good pin enable, low drives
);
    import tlpg_pkg::*;

    // hot limit reaches 57 degC and cold limit -7 degC: needs 7 signed bits
    if (TEMP_W < 7 || TEMP_W > 16) begin : g_bad_temp_w
        $error("tlpg_regs: TEMP_W must lie in 7..16");
    end

    localparam logic signed [TEMP_W-1:0] HOT_BASE = TEMP_W'(`TLPG_HOT_BASE_DEGC);
    localparam logic signed [TEMP_W-1:0] COLD_BASE = TEMP_W'(`TLPG_COLD_BASE_DEGC);
    localparam int RAIL_W = $bits(tlpg_rails_t);

    function automatic logic signed [TEMP_W-1:0] limitDeg(
        input logic [3:0] code,
        input logic signed [TEMP_W-1:0] base
    );
        logic signed [TEMP_W-1:0] step;
        step = $signed({{(TEMP_W - 4){1'b0}}, code});
        return TEMP_W'(base + step);
    endfunction

    function automatic tlpg_sel_t decodeAddr(input logic [7:0] addr);
        tlpg_sel_t sel;
        case (addr)
            `TLPG_THR_OFS: sel = TLPG_SEL_THR;
            `TLPG_PGS_OFS: sel = TLPG_SEL_PGS;
            `TLPG_REV_OFS: sel = TLPG_SEL_REV;
            `TLPG_TSTAT_OFS: sel = TLPG_SEL_TSTAT;
            `TLPG_TLAST_OFS: sel = TLPG_SEL_TLAST;
            default: sel = TLPG_SEL_NONE;
        endcase
        return sel;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // rail good inputs come from the analog side, so they are synchronised
    logic [RAIL_W-1:0] railSyncBits;
    tlpg_rails_t railSync;

    tlpg_sync #(
        .WIDTH(RAIL_W)
    ) u_rail_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .asyncIn(railGoodPins),
        .syncOut(railSyncBits)
    );

    assign railSync = tlpg_rails_t'(railSyncBits);

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    tlpg_sel_t wrSel;
    tlpg_sel_t rdSel;
    logic thrWrite;

    assign wrSel = decodeAddr(busReq.addr);
    assign rdSel = decodeAddr(busReq.addr);
    // writes to read-only or unmapped offsets are dropped silently
    assign thrWrite = busReq.wrStb && (wrSel == TLPG_SEL_THR);

    ////////////////////////////////////////////////////////////////////////////
    // thermistor limit register
    logic [7:0] thr_q;
    logic [7:0] thr_d;
    logic [3:0] coldLimitCode;
    logic [3:0] hotLimitCode;

    assign thr_d = thrWrite ? busReq.wrData : thr_q;
    assign coldLimitCode = thr_q[`TLPG_COLD_MSB:`TLPG_COLD_LSB];
    assign hotLimitCode = thr_q[`TLPG_HOT_MSB:`TLPG_HOT_LSB];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            thr_q <= `TLPG_THR_RST;
        end else begin
            thr_q <= thr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-good status: each rail bit follows its synchronised rail level, bits 2 and 0 stay zero
    logic [7:0] pgStatus_q;
    logic [7:0] pgStatus_d;
    logic pgRelease_q;
    logic pgRelease_d;

    always_comb begin
        pgStatus_d = `TLPG_PGS_RST;
        pgStatus_d[`TLPG_PGS_BOOST_BIT] = railSync.boostRailGood;
        pgStatus_d[`TLPG_PGS_GATEHI_BIT] = railSync.gateHighRailGood;
        pgStatus_d[`TLPG_PGS_INV_BIT] = railSync.inverterRailGood;
        pgStatus_d[`TLPG_PGS_SRCPOS_BIT] = railSync.sourcePosRailGood;
        pgStatus_d[`TLPG_PGS_GATELO_BIT] = railSync.gateLowRailGood;
        pgStatus_d[`TLPG_PGS_SRCNEG_BIT] = railSync.sourceNegRailGood;
    end

    // the boost and inverter rails feed the others, so only the four panel
    // rails gate the pin
    assign pgRelease_d = pgStatus_d[`TLPG_PGS_GATEHI_BIT]
        && pgStatus_d[`TLPG_PGS_SRCPOS_BIT]
        && pgStatus_d[`TLPG_PGS_GATELO_BIT]
        && pgStatus_d[`TLPG_PGS_SRCNEG_BIT];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pgStatus_q <= `TLPG_PGS_RST;
            pgRelease_q <= 1'b0;
        end else begin
            pgStatus_q <= pgStatus_d;
            pgRelease_q <= pgRelease_d;
        end
    end

    // open drain: never drive high, only pull low or release
    assign powerGoodOutputO = 1'b0;
    assign powerGoodOutputEnN = pgRelease_q;

    ////////////////////////////////////////////////////////////////////////////
    // temperature compare against the limits in force at sample time
    logic signed [TEMP_W-1:0] hotDeg;
    logic signed [TEMP_W-1:0] coldDeg;
    logic hotHit;
    logic coldHit;
    logic hotIrq_q;
    logic coldIrq_q;
    logic hotActive_q;
    logic coldActive_q;
    logic signed [TEMP_W-1:0] tempLast_q;

    assign hotDeg = limitDeg(hotLimitCode, HOT_BASE);
    assign coldDeg = limitDeg(coldLimitCode, COLD_BASE);
    assign hotHit = tempValid && (tempDegC >= hotDeg);
    assign coldHit = tempValid && (tempDegC <= coldDeg);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hotIrq_q <= 1'b0;
            coldIrq_q <= 1'b0;
        end else begin
            hotIrq_q <= hotHit;
            coldIrq_q <= coldHit;
        end
    end

    // levels hold the verdict of the latest sample until the next one
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hotActive_q <= 1'b0;
            coldActive_q <= 1'b0;
            tempLast_q <= '0;
        end else if (tempValid) begin
            hotActive_q <= hotHit;
            coldActive_q <= coldHit;
            tempLast_q <= tempDegC;
        end
    end

    assign hotIrq = hotIrq_q;
    assign coldIrq = coldIrq_q;

    ////////////////////////////////////////////////////////////////////////////
    // read path: data stands for exactly one cycle, zero otherwise
    logic [7:0] revByte;
    logic [7:0] tstatByte;
    logic [7:0] tlastByte;
    logic [7:0] rdMux;
    logic [7:0] rdData_q;

    assign revByte = {MAJOR_REV, MINOR_REV, VERSION_NUM};
    assign tstatByte = {6'h00, hotActive_q, coldActive_q};
    // sample is reported as its low eight bits, two's complement
    assign tlastByte = 8'(tempLast_q);

    always_comb begin
        case (rdSel)
            TLPG_SEL_THR: rdMux = thr_q;
            TLPG_SEL_PGS: rdMux = pgStatus_q;
            TLPG_SEL_REV: rdMux = revByte;
            TLPG_SEL_TSTAT: rdMux = tstatByte;
            TLPG_SEL_TLAST: rdMux = tlastByte;
            default: rdMux = `TLPG_BYTE_ZERO;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdData_q <= `TLPG_BYTE_ZERO;
        end else begin
            rdData_q <= busReq.rdStb ? rdMux : `TLPG_BYTE_ZERO;
        end
    end

    assign rdData = rdData_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    chk_cold_write: assert property (
        busReq.wrStb && busReq.addr == `TLPG_THR_OFS
        |=> thr_q[`TLPG_COLD_MSB:`TLPG_COLD_LSB] == $past(busReq.wrData[7:4])
    ) else $error("cold limit did not take written value");

    chk_hot_write: assert property (
        busReq.wrStb && busReq.addr == `TLPG_THR_OFS
        |=> thr_q[`TLPG_HOT_MSB:`TLPG_HOT_LSB] == $past(busReq.wrData[3:0])
        ##2 $stable(thr_q) || $past(busReq.wrStb)
    ) else $error("hot limit wrong after write");

    chk_hot_irq: assert property (
        tempValid |=> hotIrq == ($past(tempDegC) >= $past(hotDeg))
    ) else $error("hot interrupt disagrees with sample");

    chk_cold_irq: assert property (
        tempValid |=> coldIrq == ($past(tempDegC) <= $past(coldDeg))
    ) else $error("cold interrupt disagrees with sample");

    chk_irq_quiet: assert property (
        !tempValid |=> !hotIrq && !coldIrq
    ) else $error("interrupt without a sample");

    chk_pgs_read: assert property (
        busReq.rdStb && busReq.addr == `TLPG_PGS_OFS
        |=> rdData == $past(pgStatus_q)
    ) else $error("status read returned wrong byte");

    chk_pg_pin: assert property (
        powerGoodOutputEnN == (pgStatus_q[`TLPG_PGS_GATEHI_BIT]
            && pgStatus_q[`TLPG_PGS_SRCPOS_BIT]
            && pgStatus_q[`TLPG_PGS_GATELO_BIT]
            && pgStatus_q[`TLPG_PGS_SRCNEG_BIT]) && !powerGoodOutputO
    ) else $error("power-good pin does not match status");

    chk_boost_bit: assert property (
        pgStatus_q[`TLPG_PGS_BOOST_BIT] == $past(railSync.boostRailGood)
    ) else $error("boost status bit wrong");

    chk_gatehi_bit: assert property (
        $rose(railSync.gateHighRailGood) |=> pgStatus_q[`TLPG_PGS_GATEHI_BIT]
    ) else $error("gate-high status bit did not rise");

    chk_inv_bit: assert property (
        !railSync.inverterRailGood |=> !pgStatus_q[`TLPG_PGS_INV_BIT]
    ) else $error("inverter status bit set while out of regulation");

    chk_srcpos_bit: assert property (
        pgStatus_q[`TLPG_PGS_SRCPOS_BIT] |-> $past(railSync.sourcePosRailGood)
    ) else $error("source-pos status bit set without rail");

    chk_gatelo_bit: assert property (
        railSync.gateLowRailGood [*2] |=> pgStatus_q[`TLPG_PGS_GATELO_BIT]
    ) else $error("gate-low status bit not set");

    chk_srcneg_bit: assert property (
        pgStatus_q[`TLPG_PGS_SRCNEG_BIT] == $past(railSync.sourceNegRailGood)
    ) else $error("source-neg status bit wrong");

    chk_unused_bits: assert property (
        !pgStatus_q[`TLPG_PGS_UNUSED2_BIT] && !pgStatus_q[`TLPG_PGS_UNUSED0_BIT]
    ) else $error("unused status bits not zero");

    chk_rev_read: assert property (
        busReq.rdStb && busReq.addr == `TLPG_REV_OFS
        |=> rdData[`TLPG_REV_MAJ_MSB:`TLPG_REV_MAJ_LSB] == MAJOR_REV
            && rdData[`TLPG_REV_MIN_MSB:`TLPG_REV_MIN_LSB] == MINOR_REV
            && rdData[`TLPG_REV_VER_MSB:`TLPG_REV_VER_LSB] == VERSION_NUM
    ) else $error("revision read returned wrong fields");

    chk_thr_hold: assert property (
        !(busReq.wrStb && busReq.addr == `TLPG_THR_OFS) |=> $stable(thr_q)
    ) else $error("threshold changed without a write");

    chk_thr_read: assert property (
        busReq.rdStb && busReq.addr == `TLPG_THR_OFS
        |=> rdData[`TLPG_COLD_MSB:`TLPG_COLD_LSB] == $past(coldLimitCode)
            && rdData[`TLPG_HOT_MSB:`TLPG_HOT_LSB] == $past(hotLimitCode)
    ) else $error("threshold read returned wrong byte");

    chk_pgs_write: assert property (
        busReq.wrStb && busReq.addr == `TLPG_PGS_OFS
        |=> pgStatus_q == $past(pgStatus_d)
    ) else $error("write disturbed the status register");

    chk_rd_idle: assert property (
        !busReq.rdStb |=> rdData == `TLPG_BYTE_ZERO
    ) else $error("read data stands outside its cycle");

    chk_unmapped_rd: assert property (
        busReq.rdStb && rdSel == TLPG_SEL_NONE |=> rdData == `TLPG_BYTE_ZERO
    ) else $error("unmapped read returned data");

    chk_tstat_read: assert property (
        busReq.rdStb && busReq.addr == `TLPG_TSTAT_OFS
        |=> rdData[`TLPG_TSTAT_HOT_BIT] == $past(hotActive_q)
            && rdData[`TLPG_TSTAT_COLD_BIT] == $past(coldActive_q)
    ) else $error("temperature level read wrong");

    chk_level_track: assert property (
        tempValid |=> hotActive_q == hotIrq && coldActive_q == coldIrq
    ) else $error("level flags disagree with pulses");

    chk_level_hold: assert property (
        !tempValid |=> $stable(hotActive_q) && $stable(coldActive_q) && $stable(tempLast_q)
    ) else $error("level flags moved without a sample");

    chk_tlast_capture: assert property (
        tempValid |=> tempLast_q == $past(tempDegC)
    ) else $error("last sample not captured");

    chk_pg_gatehi_drop: assert property (
        !railSync.gateHighRailGood |=> !powerGoodOutputEnN
    ) else $error("power-good pin released with gate-high rail down");

    chk_pg_srcneg_drop: assert property (
        !railSync.sourceNegRailGood |=> !powerGoodOutputEnN
    ) else $error("power-good pin released with source-neg rail down");

endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tlpg_defines.svh"

module tb_top;
    import tlpg_pkg::*;

    localparam logic [1:0] REV_MAJ = 2'h1; // arbitrary value
    localparam logic [1:0] REV_MIN = 2'h2; // arbitrary value
    localparam logic [3:0] REV_VER = 4'h3; // arbitrary value

    logic core_clk;
    logic rstn;
    tlpg_bus_req_t busReq;
    logic [7:0] rdData;
    tlpg_rails_t railGoodPins;
    logic tempValid;
    logic signed [7:0] tempDegC;
    logic hotIrq;
    logic coldIrq;
    logic powerGoodOutputO;
    logic powerGoodOutputEnN;
    int errTotal;
    int totalChecks;
    logic [15:0] lfsrVal;
    logic [7:0] thrVal;
    logic [5:0] railVal;
    int hotLim;
    int coldLim;
    int tVal;

    tlpg_regs #(
        .TEMP_W(8),
        .MAJOR_REV(REV_MAJ),
        .MINOR_REV(REV_MIN),
        .VERSION_NUM(REV_VER)
    ) dut (
        .core_clk(core_clk),
        .rstn(rstn),
        .busReq(busReq),
        .rdData(rdData),
        .railGoodPins(railGoodPins),
        .tempValid(tempValid),
        .tempDegC(tempDegC),
        .hotIrq(hotIrq),
        .coldIrq(coldIrq),
        .powerGoodOutputO(powerGoodOutputO),
        .powerGoodOutputEnN(powerGoodOutputEnN)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nextRand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [7:0] expStatus(input tlpg_rails_t r);
        return {r.boostRailGood, r.gateHighRailGood, r.inverterRailGood, r.sourcePosRailGood,
                r.gateLowRailGood, 1'b0, r.sourceNegRailGood, 1'b0};
    endfunction

    // released pin shows as a high enable, i.e. the driver is off
    function automatic logic expRelease(input tlpg_rails_t r);
        return r.gateHighRailGood & r.sourcePosRailGood & r.gateLowRailGood
               & r.sourceNegRailGood;
    endfunction

    // latest-sample verdicts: bit 1 hot, bit 0 cold
    function automatic logic [7:0] expLevel(input int t, input int hi, input int lo);
        return {6'h00, (t >= hi), (t <= lo)};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stopTest();
        if (errTotal == 0 && totalChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic checkBit(input string what, input logic exp, input logic got);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic busWrite(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        busReq <= '{wrStb: 1'b1, rdStb: 1'b0, addr: addr, wrData: data};
        @(posedge core_clk);
        busReq <= '0;
    endtask

    // read data stands only in the cycle after the strobe, so sample just past that edge
    task automatic readCheck(input string what, input logic [7:0] addr, input logic [7:0] exp);
        @(posedge core_clk);
        busReq <= '{wrStb: 1'b0, rdStb: 1'b1, addr: addr, wrData: 8'h00};
        @(posedge core_clk);
        busReq <= '0;
        #1;
        checkByte(what, exp, rdData);
    endtask

    // rails cross two sync flops plus the status flop before they are visible
    task automatic setRails(input tlpg_rails_t r);
        @(posedge core_clk);
        railGoodPins <= r;
        repeat (4) @(posedge core_clk);
        #1;
        checkBit("power good enable", expRelease(r), powerGoodOutputEnN);
        checkBit("power good drive", 1'b0, powerGoodOutputO);
        readCheck("power good status", `TLPG_PGS_OFS, expStatus(r));
    endtask

    task automatic sendTemp(input int t);
        @(posedge core_clk);
        tempValid <= 1'b1;
        tempDegC <= t[7:0];
        @(posedge core_clk);
        tempValid <= 1'b0;
        #1;
        checkBit("hot interrupt", (t >= hotLim), hotIrq);
        checkBit("cold interrupt", (t <= coldLim), coldIrq);
        @(posedge core_clk);
        #1;
        checkBit("hot pulse end", 1'b0, hotIrq);
        checkBit("cold pulse end", 1'b0, coldIrq);
        readCheck("temp level", `TLPG_TSTAT_OFS, expLevel(t, hotLim, coldLim));
        readCheck("last sample", `TLPG_TLAST_OFS, t[7:0]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk);
        errTotal++;
        stopTest();
    end

    initial begin
        rstn = 1'b0;
        busReq = '0;
        railGoodPins = '0;
        tempValid = 1'b0;
        tempDegC = '0;
        errTotal = 0;
        totalChecks = 0;
        lfsrVal = 16'h0014;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        checkBit("enable at reset", 1'b0, powerGoodOutputEnN);
        readCheck("threshold reset", `TLPG_THR_OFS, {4'h7, 4'h8});
        readCheck("status reset", `TLPG_PGS_OFS, 8'h00);
        readCheck("revision", `TLPG_REV_OFS, {REV_MAJ, REV_MIN, REV_VER});
        // writes to read-only and unmapped places must leave everything alone
        busWrite(`TLPG_PGS_OFS, 8'hFF);
        busWrite(`TLPG_REV_OFS, 8'hFF);
        busWrite(8'h3C, 8'h55);
        readCheck("status after write", `TLPG_PGS_OFS, 8'h00);
        readCheck("revision after write", `TLPG_REV_OFS, {REV_MAJ, REV_MIN, REV_VER});
        readCheck("unmapped read", 8'h3C, 8'h00);
        readCheck("threshold kept", `TLPG_THR_OFS, 8'h78);
        for (int i = 0; i < 28; i++) begin
            lfsrVal = nextRand(lfsrVal);
            railVal = (i < 6) ? (6'h01 << i) : (i == 6) ? 6'h3F : (i == 7) ? 6'h17 :
                      (i == 8) ? 6'h16 : lfsrVal[5:0];
            setRails(railVal);
        end
        for (int i = 0; i < 12; i++) begin
            lfsrVal = nextRand(lfsrVal);
            thrVal = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : lfsrVal[7:0];
            busWrite(`TLPG_THR_OFS, thrVal);
            readCheck("threshold readback", `TLPG_THR_OFS, thrVal);
            hotLim = 42 + int'(thrVal[3:0]);
            coldLim = -7 + int'(thrVal[7:4]);
            sendTemp(hotLim - 1);
            sendTemp(hotLim);
            sendTemp(coldLim);
            sendTemp(coldLim + 1);
            lfsrVal = nextRand(lfsrVal);
            tVal = int'($signed(lfsrVal[7:0]));
            sendTemp(tVal);
        end
        // a second reset mid-run must bring the defaults back
        @(posedge core_clk);
        rstn <= 1'b0;
        @(posedge core_clk);
        rstn <= 1'b1;
        railGoodPins <= '0;
        readCheck("threshold second reset", `TLPG_THR_OFS, 8'h78);
        readCheck("status second reset", `TLPG_PGS_OFS, 8'h00);
        readCheck("level second reset", `TLPG_TSTAT_OFS, 8'h00);
        readCheck("sample second reset", `TLPG_TLAST_OFS, 8'h00);
        stopTest();
    end
endmodule
`default_nettype wire
